// ### verif/iis_intr_status_chk.sv
// checker of the interrupt status block, watching its ports only
// assumes one wait-free apb access after each setup cycle
`timescale 1ns/1ps
module iis_chk
(
   input wire logic                        SYS_CLK_IN,
   input wire logic                        NRST_IN,
   input wire logic                        PSEL_IN,
   input wire logic                        PENABLE_IN,
   input wire logic                        PWRITE_IN,
   input wire logic [iis_pkg::ADDR_W-1:0]  PADDR_IN,
   input wire logic [iis_pkg::DATA_W-1:0]  PWDATA_IN,
   input wire logic [iis_pkg::DATA_W-1:0]  PRDATA_OUT,
   input wire logic                        PREADY_OUT,
   input wire logic                        PSLVERR_OUT,
   input wire logic                        INTR_OUT,
   input wire logic                        SCL_OE_OUT
);
   import iis_pkg::*;
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (!NRST_IN);
   logic [11:0] msk;
   logic        fed;
   wire         su = PSEL_IN && !PENABLE_IN;
   wire         ac = PSEL_IN && PENABLE_IN && PREADY_OUT;
   wire         rd = ac && !PWRITE_IN;
   wire         st = rd && PADDR_IN == A_INTR_STAT;
   ////////////////////////////////////////////////////////////
   // shadow mask and byte-written flag
   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
      if (!NRST_IN)
         msk <= MASK_RST;
      else if (ac && PWRITE_IN && PADDR_IN == A_INTR_MASK)
         msk <= PWDATA_IN[11:0];
   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
      if (!NRST_IN)
         fed <= 1'b0;
      else if (ac && PWRITE_IN && PADDR_IN == A_DATA_CMD)
         fed <= 1'b1;
      else if ($rose(SCL_OE_OUT))
         fed <= 1'b0;
   sequence clr_rq;
      rd && PADDR_IN == A_CLR_RD_REQ;
   endsequence
   sequence raw_su;
      su && !PWRITE_IN && PADDR_IN == A_RAW_STAT;
   endsequence
   chk_ready_one:
      assert property (su |=> PREADY_OUT)
      else $error("no ready after setup");
   chk_ready_drop:
      assert property (PREADY_OUT |=> !PREADY_OUT)
      else $error("ready held");
   chk_rsvd_zero:
      assert property (st |-> PRDATA_OUT[31:11] == 0)
      else $error("reserved bits set");
   chk_mask_gate:
      assert property (st |-> (PRDATA_OUT[11:0] & ~msk) == 0)
      else $error("masked bit visible");
   chk_intr_follow:
      assert property (st |-> INTR_OUT == (PRDATA_OUT != 0))
      else $error("interrupt line wrong");
   chk_rdreq_clear:
      assert property (clr_rq ##2 raw_su |=> !PRDATA_OUT[B_RDREQ])
      else $error("read request kept");
   chk_scl_hold:
      assert property ($fell(SCL_OE_OUT) |-> fed)
      else $error("clock released unserved");
   chk_slverr_zero:
      assert property (PSLVERR_OUT |-> PREADY_OUT && PRDATA_OUT == 0)
      else $error("error with data");
endmodule
bind iis_intr_status iis_chk iis_chk_i (.SYS_CLK_IN, .NRST_IN, .PSEL_IN,
   .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PRDATA_OUT,
   .PREADY_OUT, .PSLVERR_OUT, .INTR_OUT, .SCL_OE_OUT);

// ### verif/iis_intr_status_tb.sv
// self-checking bench of the interrupt status block
// assumes the remote master model and the bound checker
`timescale 1ns/1ps
module iis_intr_status_tb;
   import iis_pkg::*;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   localparam logic [31:0] ONE = 32'h0000_0001;
   logic        SYS_CLK_IN, LINK_CLK_IN, NRST_IN, PSEL_IN, PENABLE_IN;
   logic        PWRITE_IN, PREADY_OUT, PSLVERR_OUT, INTR_OUT, rx_v;
   logic        SCL_OUT, SCL_OE_OUT, SDA_OUT, SDA_OE_OUT, m_scl, m_sda;
   logic [31:0] PADDR_IN, PWDATA_IN, PRDATA_OUT, lf;
   logic [63:0] n;
   logic [7:0]  rx;
   logic [63:0] aq[$];
   logic [7:0]  bq[$];
   int          errors, total_checks, cyc;
   wire         SCL_IN = !(SCL_OE_OUT && !SCL_OUT) && !m_scl;
   wire         SDA_IN = !(SDA_OE_OUT && !SDA_OUT) && !m_sda;
   iis_intr_status iis_intr_status_i (.*);
   iis_rmaster iis_rmaster_i (.scl_in(SCL_IN), .sda_in(SDA_IN),
      .scl_oe_out(m_scl), .sda_oe_out(m_sda), .rx_out(rx), .rx_v_out(rx_v));
   ////////////////////////////////////////////////////////////
   // clocks, timeout, monitors
   initial
   begin
      SYS_CLK_IN = 0;
      forever #4 SYS_CLK_IN = !SYS_CLK_IN;
   end
   initial
   begin
      LINK_CLK_IN = 0;
      #1.7;
      forever #3 LINK_CLK_IN = !LINK_CLK_IN;
   end
   always @(posedge SYS_CLK_IN)
      if (++cyc > 20000)
      begin
         errors++;
         wrap_up();
      end
   always @(posedge SYS_CLK_IN)
      if (PSEL_IN && PENABLE_IN && PREADY_OUT && !PWRITE_IN)
      begin
         n = aq.pop_front();
         cmp_w(PRDATA_OUT, n[63:32], n[31:0]);
      end
   always @(posedge rx_v)
      cmp_b(rx, bq.pop_front());
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic cmp_w(input logic [31:0] g, e, m);
      total_checks++;
      if ((g & m) !== (e & m))
      begin
         errors++;
         $display("BAD t=%0t got %h exp %h", $time, g & m, e & m);
      end
   endtask
   task automatic cmp_b(input logic [7:0] g, e);
      cmp_w({24'h00_0000, g}, {24'h00_0000, e}, 32'h0000_00FF);
   endtask
   task automatic ap(input logic w, input logic [31:0] a, d = 0, e = 0,
                     m = ALL);
      if (!w)
         aq.push_back({e, m});
      @(posedge SYS_CLK_IN);
      #1 {PSEL_IN, PENABLE_IN, PWRITE_IN} = {2'b10, w};
      {PADDR_IN, PWDATA_IN} = {a, d};
      @(posedge SYS_CLK_IN);
      #1 PENABLE_IN = 1;
      @(posedge SYS_CLK_IN);
      #1 {PSEL_IN, PENABLE_IN} = 2'b00;
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      {NRST_IN, PSEL_IN, PENABLE_IN, PWRITE_IN, PADDR_IN, PWDATA_IN} = 0;
      lf = 32'hd70f_02c2;
      repeat (3) @(posedge SYS_CLK_IN);
      #1 NRST_IN = 1;
      repeat (3) @(posedge SYS_CLK_IN);
      ap(0, A_INTR_MASK, 0, 32'h0000_08FF);
      ap(0, A_INTR_STAT, 0, 0);
      ap(1, A_ENABLE, ONE);
      ap(1, A_INTR_MASK, 32'h0000_0FFF);
      ap(0, A_RAW_STAT, 0, 32'h0000_0010);
      ap(1, A_INTR_MASK, 32'h0000_0FEF);
      ap(0, A_INTR_STAT, 0, 0);
      ap(1, A_INTR_MASK, 32'h0000_0020);
      lf = nx(lf);
      ap(1, A_DATA_CMD, lf);
      ap(0, A_RAW_STAT, 0, 32'h0000_0100);
      $display("test status basics done");
      lf = nx(lf);
      bq.push_back(lf[7:0]);
      fork
         iis_rmaster_i.rd(SLV_ADDR_RST);
         begin
            repeat (2) @(posedge SYS_CLK_IN);
            for (int i = 0; i < 3000 && INTR_OUT !== 1'b1; i++)
               @(posedge SYS_CLK_IN);
            ap(0, A_INTR_STAT, 0, 32'h0000_0020);
            ap(0, A_ABRT_SRC, 0, ONE, ONE);
            ap(0, A_RAW_STAT, 0, 32'h0000_0060, 32'h0000_0060);
            ap(1, A_DATA_CMD, ~lf);
            ap(0, A_TXFLR, 0, 0);
            ap(0, A_CLR_TX_ABRT, 0, 0, 0);
            ap(0, A_CLR_RD_REQ, 0, ONE, ONE);
            ap(0, A_RAW_STAT, 0, 0, 32'h0000_0060);
            ap(1, A_DATA_CMD, lf);
         end
      join
      repeat (20) @(posedge SYS_CLK_IN);
      ap(0, A_RAW_STAT, 0, 32'h0000_0790);
      ap(0, A_CLR_ACT, 0, 0, 0);
      ap(0, A_RAW_STAT, 0, 32'h0000_0690);
      ap(0, A_CLR_INTR, 0, 0, 0);
      ap(0, A_RAW_STAT, 0, 32'h0000_0010);
      $display("test slave read done");
      for (int i = 0; i < 33; i++)
      begin
         lf = nx(lf);
         ap(1, A_DATA_CMD, lf);
      end
      ap(0, A_TXFLR, 0, 32'h0000_0020);
      ap(0, A_RAW_STAT, 0, 32'h0000_0108);
      ap(1, A_ENABLE, 0);
      repeat (4) @(posedge SYS_CLK_IN);
      ap(0, A_RAW_STAT, 0, 0);
      ap(0, A_TXFLR, 0, 0);
      ap(0, 32'h5000_1500, 0, 0);
      $display("test overflow and disable done");
      wrap_up();
   end
endmodule

// ### verif/iis_rmaster.sv
// remote i2c master model reading one byte from the slave
// assumes the bench resolves the open-drain lines with pull-ups
`timescale 1ns/1ps
module iis_rmaster
(
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            scl_oe_out,
   output logic            sda_oe_out,
   output logic [7:0]      rx_out,
   output logic            rx_v_out
);
   localparam int Q = 40;
   initial
   begin
      {scl_oe_out, sda_oe_out, rx_v_out} = 3'h0;
      rx_out = 8'h00;
   end
   task automatic wt();
      for (int i = 0; i < 4000 && !scl_in; i++)
         #10;
   endtask
   task automatic bx(input logic b, output logic r);
      sda_oe_out = !b;
      #Q scl_oe_out = 0;
      wt();
      #Q r = sda_in;
      #Q scl_oe_out = 1;
      #Q;
   endtask
   task automatic rd(input logic [6:0] a);
      logic       r;
      logic [7:0] d;
      logic [7:0] ab;
      ab = {a, 1'b1};
      #Q sda_oe_out = 1;
      #Q scl_oe_out = 1;
      for (int i = 7; i >= 0; i--)
         bx(ab[i], r);
      bx(1'b1, r);
      for (int i = 7; i >= 0; i--)
      begin
         bx(1'b1, r);
         d[i] = r;
      end
      bx(1'b1, r); // last byte not acknowledged
      #Q sda_oe_out = 1;
      #Q scl_oe_out = 0;
      wt();
      #Q sda_oe_out = 0;
      rx_out = d;
      #Q rx_v_out = 1;
      #Q rx_v_out = 0;
   endtask
endmodule

// ### verilog/iis_intr_status.sv
// i2c controller interrupt status block: apb register port, transmit
// fifo, status flags and a small slave-transmitter link engine.
// assumes scl/sda arrive on pins outside both clocks; the link engine runs
// on LINK_CLK_IN; it reads slv_addr and hand_data directly, all else through synchronisers.
`timescale 1ns/1ps
module iis_intr_status
#(
   parameter int unsigned DEPTH = 32
)
(
   input  wire logic                         SYS_CLK_IN,
   input  wire logic                         NRST_IN,
   input  wire logic                         LINK_CLK_IN,
   input  wire logic                         PSEL_IN,
   input  wire logic                         PENABLE_IN,
   input  wire logic                         PWRITE_IN,
   input  wire logic [iis_pkg::ADDR_W-1:0]   PADDR_IN,
   input  wire logic [iis_pkg::DATA_W-1:0]   PWDATA_IN,
   output logic      [iis_pkg::DATA_W-1:0]   PRDATA_OUT,
   output logic                              PREADY_OUT,
   output logic                              PSLVERR_OUT,
   output logic                              INTR_OUT,
   input  wire logic                         SCL_IN,
   output logic                              SCL_OUT,
   output logic                              SCL_OE_OUT,
   input  wire logic                         SDA_IN,
   output logic                              SDA_OUT,
   output logic                              SDA_OE_OUT
);
   import iis_pkg::*;

   localparam int unsigned CW = $clog2(DEPTH + 1);
   localparam int unsigned PW = $clog2(DEPTH);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

   ////////////////////////////////////////////////////////////////////////
   // declarations
   logic [BYTE_W-1:0]   fifo_mem [DEPTH];
   logic [PW-1:0]       wr_ptr;
   logic [PW-1:0]       rd_ptr;
   logic [CW-1:0]       count;
   logic                enable;
   logic                internal_enable_signal;
   logic [MASK_W-1:0]   mask;
   logic [7:0]          tx_tl;
   logic [6:0]          slv_addr;
   logic                f_start;
   logic                f_stop;
   logic                f_act;
   logic                f_done;
   logic                f_abrt;
   logic                f_rdreq;
   logic                f_over;
   logic                cause_flush;
   logic                svc_pending;
   logic [BYTE_W-1:0]   hand_data;
   logic                data_tgl;
   iis_evt_t            ev_l;
   iis_evt_t            ev_s1;
   iis_evt_t            ev_s2;
   iis_evt_t            ev_s3;
   iis_evt_t            ev;
   logic                busy_l;
   logic                busy_s1;
   logic                busy_s2;
   logic                access;
   logic                rd_acc;
   logic                wr_acc;
   logic                setup;
   logic                mapped;
   logic                flush;
   logic                push;
   logic                pop;
   logic                over_evt;
   logic                abrt_evt;
   logic                clr_all;
   logic                disable_wr;
   logic                tx_empty;
   logic [15:0]         raw_stat;
   logic [15:0]         mask_stat;
   logic [31:0]         next_rdata;

   ////////////////////////////////////////////////////////////////////////
   // apb decode; read effects land in the access cycle
   assign setup   = PSEL_IN & ~PENABLE_IN;
   assign access  = PSEL_IN & PENABLE_IN & PREADY_OUT;
   assign rd_acc  = access & ~PWRITE_IN;
   assign wr_acc  = access & PWRITE_IN;
   assign clr_all = rd_acc & (PADDR_IN == A_CLR_INTR);
   assign disable_wr = wr_acc & (PADDR_IN == A_ENABLE) & ~PWDATA_IN[0];

   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         PRDATA_OUT  <= '0;
         PREADY_OUT  <= 1'h0;
         PSLVERR_OUT <= 1'h0;
      end
      else
      begin
         PREADY_OUT  <= setup;
         PSLVERR_OUT <= setup & ~mapped;
         if (setup)
            PRDATA_OUT <= next_rdata;
      end
   end

   always_comb
   begin
      next_rdata = '0;
      mapped     = 1'h1;
      case (PADDR_IN)
         A_SLAVE_ADDR  : next_rdata[6:0] = slv_addr;
         A_DATA_CMD    : next_rdata = '0;
         A_INTR_STAT   : next_rdata[15:0] = mask_stat;
         A_INTR_MASK   : next_rdata[MASK_W-1:0] = mask;
         A_RAW_STAT    : next_rdata[15:0] = raw_stat;
         A_TX_TL       : next_rdata[7:0] = tx_tl;
         A_CLR_INTR    : next_rdata[0] = |raw_stat;
         A_CLR_RD_REQ  : next_rdata[0] = f_rdreq;
         A_CLR_TX_ABRT : next_rdata[0] = f_abrt;
         A_CLR_ACT     : next_rdata[0] = f_act;
         A_ENABLE      : next_rdata[0] = enable;
         A_TXFLR       : next_rdata[CW-1:0] = count;
         A_ABRT_SRC    : next_rdata[B_SLVFLSH] = cause_flush;
         default       : mapped = 1'h0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // software writable registers
   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         enable   <= 1'h0;
         mask     <= MASK_RST;
         tx_tl    <= TX_TL_RST;
         slv_addr <= SLV_ADDR_RST;
      end
      else if (wr_acc)
      begin
         case (PADDR_IN)
            A_ENABLE     : enable   <= PWDATA_IN[0];
            A_INTR_MASK  : mask     <= PWDATA_IN[MASK_W-1:0];
            A_TX_TL      : tx_tl    <= PWDATA_IN[7:0];
            A_SLAVE_ADDR : slv_addr <= PWDATA_IN[6:0];
            default      : ;
         endcase
      end
   end

   // internal enable stays up until a bus stop clears the link busy flag
   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
         internal_enable_signal <= 1'h0;
      else
         internal_enable_signal <= enable | busy_s2;
   end

   ////////////////////////////////////////////////////////////////////////
   // link to system crossing: toggles and busy level through two flops
   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         ev_s1   <= '0;
         ev_s2   <= '0;
         ev_s3   <= '0;
         busy_s1 <= 1'h0;
         busy_s2 <= 1'h0;
      end
      else
      begin
         ev_s1   <= ev_l;
         ev_s2   <= ev_s1;
         ev_s3   <= ev_s2;
         busy_s1 <= busy_l;
         busy_s2 <= busy_s1;
      end
   end

   assign ev = ev_s2 ^ ev_s3;

   ////////////////////////////////////////////////////////////////////////
   // transmit fifo
   assign flush    = ~enable | f_abrt;
   assign push     = wr_acc & (PADDR_IN == A_DATA_CMD) & ~flush
                   & (count != FULL_CNT);
   assign over_evt = wr_acc & (PADDR_IN == A_DATA_CMD) & ~flush
                   & (count == FULL_CNT);
   assign pop      = svc_pending & ~flush & (count != '0);
   assign abrt_evt = ev.rdreq & enable & (count != '0);

   always_ff @(posedge SYS_CLK_IN)
   begin
      if (push)
         fifo_mem[wr_ptr] <= PWDATA_IN[BYTE_W-1:0];
   end

   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else if (flush)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= PW'(wr_ptr + 1'h1);
         if (pop)
            rd_ptr <= PW'(rd_ptr + 1'h1);
         if (push & ~pop)
            count <= CW'(count + 1'h1);
         else if (pop & ~push)
            count <= CW'(count - 1'h1);
      end
   end

   // one byte handed to the link per read request
   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         svc_pending <= 1'h0;
         hand_data   <= '0;
         data_tgl    <= 1'h0;
      end
      else if (ev.rdreq)
         svc_pending <= 1'h1;
      else if (pop)
      begin
         svc_pending <= 1'h0;
         hand_data   <= fifo_mem[rd_ptr];
         data_tgl    <= ~data_tgl;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status flags; a set in the clearing cycle wins, but a disable write clears f_act regardless
   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         f_start <= 1'h0;
         f_stop  <= 1'h0;
         f_done  <= 1'h0;
      end
      else
      begin
         if (ev.start)
            f_start <= 1'h1;
         else if (clr_all)
            f_start <= 1'h0;
         if (ev.stop)
            f_stop <= 1'h1;
         else if (clr_all)
            f_stop <= 1'h0;
         if (ev.done)
            f_done <= 1'h1;
         else if (clr_all)
            f_done <= 1'h0;
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
         f_act <= 1'h0;
      else if (disable_wr)
         f_act <= 1'h0;
      else if (busy_s2 | ((count != '0) & ~flush))
         f_act <= 1'h1;
      else if (clr_all | (rd_acc & (PADDR_IN == A_CLR_ACT)))
         f_act <= 1'h0;
   end

   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         f_abrt      <= 1'h0;
         cause_flush <= 1'h0;
      end
      else if (abrt_evt)
      begin
         f_abrt      <= 1'h1;
         cause_flush <= 1'h1;
      end
      else if (clr_all | (rd_acc & (PADDR_IN == A_CLR_TX_ABRT)))
      begin
         f_abrt      <= 1'h0;
         cause_flush <= 1'h0;
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
         f_rdreq <= 1'h0;
      else if (ev.rdreq)
         f_rdreq <= 1'h1;
      else if (clr_all | (rd_acc & (PADDR_IN == A_CLR_RD_REQ)))
         f_rdreq <= 1'h0;
   end

   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
         f_over <= 1'h0;
      else if (over_evt)
         f_over <= 1'h1;
      else if (~internal_enable_signal | clr_all)
         f_over <= 1'h0;
   end

   ////////////////////////////////////////////////////////////////////////
   // raw and masked status, interrupt line
   assign tx_empty = enable ? ({{(8 - CW){1'b0}}, count} <= tx_tl)
                            : busy_s2;

   always_comb
   begin
      raw_stat            = '0;
      raw_stat[B_START]   = f_start;
      raw_stat[B_STOP]    = f_stop;
      raw_stat[B_ACT]     = f_act;
      raw_stat[B_TXDONE]  = f_done;
      raw_stat[B_ABRT]    = f_abrt;
      raw_stat[B_RDREQ]   = f_rdreq;
      raw_stat[B_TXEMPTY] = tx_empty;
      raw_stat[B_TXOVER]  = f_over;
   end

   assign mask_stat = raw_stat & {4'h0, mask};

   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
         INTR_OUT <= 1'h0;
      else
         INTR_OUT <= |mask_stat;
   end

   ////////////////////////////////////////////////////////////////////////
   // link domain: pin and system synchronisers
   logic                scl_s1;
   logic                scl_s2;
   logic                scl_d;
   logic                sda_s1;
   logic                sda_s2;
   logic                sda_d;
   logic                en_l1;
   logic                en_l2;
   logic                tg_l1;
   logic                tg_l2;
   logic                tg_l3;
   logic                rise;
   logic                fall;
   logic                bus_start;
   logic                bus_stop;
   iis_lstate_t         state;
   logic [2:0]          bit_cnt;
   logic [BYTE_W-1:0]   shreg;

   always_ff @(posedge LINK_CLK_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         {scl_s1, scl_s2, scl_d} <= 3'h7;
         {sda_s1, sda_s2, sda_d} <= 3'h7;
         {en_l1, en_l2}          <= 2'h0;
         {tg_l1, tg_l2, tg_l3}   <= 3'h0;
         SCL_OUT                 <= 1'h0;
         SDA_OUT                 <= 1'h0;
      end
      else
      begin
         {scl_s1, scl_s2, scl_d} <= {SCL_IN, scl_s1, scl_s2};
         {sda_s1, sda_s2, sda_d} <= {SDA_IN, sda_s1, sda_s2};
         {en_l1, en_l2}          <= {enable, en_l1};
         {tg_l1, tg_l2, tg_l3}   <= {data_tgl, tg_l1, tg_l2};
         SCL_OUT                 <= 1'h0;
         SDA_OUT                 <= 1'h0;
      end
   end

   assign rise      = scl_s2 & ~scl_d;
   assign fall      = ~scl_s2 & scl_d;
   assign bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
   assign bus_stop  = scl_s2 & scl_d & ~sda_d & sda_s2;

   ////////////////////////////////////////////////////////////////////////
   // link domain: slave transmitter engine
   always_ff @(posedge LINK_CLK_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         state      <= L_IDLE;
         bit_cnt    <= '0;
         shreg      <= '0;
         busy_l     <= 1'h0;
         ev_l       <= '0;
         SCL_OE_OUT <= 1'h0;
         SDA_OE_OUT <= 1'h0;
      end
      else if (bus_start)
      begin
         state      <= L_ADDR;
         bit_cnt    <= '0;
         busy_l     <= 1'h1;
         ev_l.start <= ~ev_l.start;
         SCL_OE_OUT <= 1'h0;
         SDA_OE_OUT <= 1'h0;
      end
      else if (bus_stop)
      begin
         state      <= L_IDLE;
         busy_l     <= 1'h0;
         ev_l.stop  <= ~ev_l.stop;
         SCL_OE_OUT <= 1'h0;
         SDA_OE_OUT <= 1'h0;
      end
      else
      begin
         case (state)
            L_ADDR :
               if (rise)
               begin
                  shreg   <= {shreg[BYTE_W-2:0], sda_s2};
                  bit_cnt <= 3'(bit_cnt + 1'h1);
                  if (bit_cnt == LAST_BIT)
                     state <= (en_l2 & sda_s2 & (shreg[6:0] == slv_addr))
                            ? L_AACK : L_IDLE;
               end
            L_AACK :
               if (fall)
               begin
                  SDA_OE_OUT <= 1'h1;
                  state      <= L_AHOLD;
               end
            L_AHOLD :
               if (fall)
               begin
                  SDA_OE_OUT <= 1'h0;
                  SCL_OE_OUT <= 1'h1;
                  ev_l.rdreq <= ~ev_l.rdreq;
                  state      <= L_WAIT;
               end
            L_WAIT :
               if (tg_l2 ^ tg_l3)
               begin
                  shreg      <= hand_data;
                  SDA_OE_OUT <= ~hand_data[BYTE_W-1];
                  bit_cnt    <= '0;
                  state      <= L_TX;
               end
            L_TX :
               // data bit settles a clock before scl is let go
               if (SCL_OE_OUT)
                  SCL_OE_OUT <= 1'h0;
               else if (fall)
               begin
                  if (bit_cnt == LAST_BIT)
                  begin
                     SDA_OE_OUT <= 1'h0;
                     state      <= L_TACK;
                  end
                  else
                  begin
                     shreg      <= {shreg[BYTE_W-2:0], 1'h0};
                     SDA_OE_OUT <= ~shreg[BYTE_W-2];
                     bit_cnt    <= 3'(bit_cnt + 1'h1);
                  end
               end
            L_TACK :
               if (rise)
               begin
                  if (sda_s2)
                  begin
                     ev_l.done <= ~ev_l.done;
                     state     <= L_IDLE;
                  end
                  else
                     state <= L_TNEXT;
               end
            L_TNEXT :
               if (fall)
               begin
                  SCL_OE_OUT <= 1'h1;
                  ev_l.rdreq <= ~ev_l.rdreq;
                  state      <= L_WAIT;
               end
            default :
               state <= L_IDLE;
         endcase
      end
   end

endmodule

// ### verilog/iis_pkg.sv
// package for the i2c interrupt status block: register map, status bit
// positions, reset values, link state and event carrier types.
// assumes a 32-bit apb-style register port and one link clock domain.
package iis_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register map, full byte addresses
   localparam int unsigned ADDR_W        = 32;
   localparam int unsigned DATA_W        = 32;
   localparam logic [31:0] A_SLAVE_ADDR  = 32'h5000_1408;
   localparam logic [31:0] A_DATA_CMD    = 32'h5000_1410;
   localparam logic [31:0] A_INTR_STAT   = 32'h5000_142C;
   localparam logic [31:0] A_INTR_MASK   = 32'h5000_1430;
   localparam logic [31:0] A_RAW_STAT    = 32'h5000_1434;
   localparam logic [31:0] A_TX_TL       = 32'h5000_143C;
   localparam logic [31:0] A_CLR_INTR    = 32'h5000_1440;
   localparam logic [31:0] A_CLR_RD_REQ  = 32'h5000_1450;
   localparam logic [31:0] A_CLR_TX_ABRT = 32'h5000_1454;
   localparam logic [31:0] A_CLR_ACT     = 32'h5000_145C;
   localparam logic [31:0] A_ENABLE      = 32'h5000_146C;
   localparam logic [31:0] A_TXFLR       = 32'h5000_1474;
   localparam logic [31:0] A_ABRT_SRC    = 32'h5000_1480;

   ////////////////////////////////////////////////////////////////////////
   // status bit positions
   localparam int B_START   = 10;
   localparam int B_STOP    = 9;
   localparam int B_ACT     = 8;
   localparam int B_TXDONE  = 7;
   localparam int B_ABRT    = 6;
   localparam int B_RDREQ   = 5;
   localparam int B_TXEMPTY = 4;
   localparam int B_TXOVER  = 3;
   localparam int B_SLVFLSH = 0;

   ////////////////////////////////////////////////////////////////////////
   // widths and reset values
   localparam int unsigned BYTE_W       = 8;
   localparam int unsigned MASK_W       = 12;
   localparam logic [11:0] MASK_RST     = 12'h8FF;
   localparam logic [7:0]  TX_TL_RST    = 8'h00;
   localparam logic [6:0]  SLV_ADDR_RST = 7'h55;
   localparam logic [2:0]  LAST_BIT     = 3'h7;

   ////////////////////////////////////////////////////////////////////////
   // link slave states and link-to-system event toggles
   typedef enum logic [2:0]
   {
      L_IDLE, L_ADDR, L_AACK, L_AHOLD, L_WAIT, L_TX, L_TACK, L_TNEXT
   } iis_lstate_t;

   typedef struct packed
   {
      logic start;
      logic stop;
      logic rdreq;
      logic done;
   } iis_evt_t;

endpackage
